/* File: design/pcr_defs.svh */
// Offsets, field positions, reset values and widths of the power configuration bank.
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

// ==========================================================
// Register port widths and offsets
// ==========================================================
`define PCR_ADDR_W          9
`define PCR_DATA_W          8
`define PCR_OFS_PHASE       9'h108
`define PCR_OFS_PIN         9'h109
`define PCR_OFS_SW_AUTO     9'h10A
`define PCR_OFS_LIN_BYP     9'h10B
`define PCR_OFS_LIN_LOW     9'h10C

// ==========================================================
// Reset values
// ==========================================================
`define PCR_RST_PHASE       8'h00
`define PCR_RST_PIN         8'h00
`define PCR_RST_SW_AUTO     8'h00
`define PCR_RST_LIN_BYP     8'h00
`define PCR_RST_LIN_LOW     8'h00
`define PCR_RDATA_NONE      8'h00

// ==========================================================
// Field positions of the phase and tracking register
// ==========================================================
`define PCR_PH_PERI         7
`define PCR_PH_IO           6
`define PCR_PH_MEM          5
`define PCR_PH_PRO          4
`define PCR_PH_CORE1        3
`define PCR_PH_DISCHG       2
`define PCR_PH_TRACK_HI     1
`define PCR_PH_TRACK_LO     0

// ==========================================================
// Field positions of the pin polarity and interface register
// ==========================================================
`define PCR_PN_FB3_POL      7
`define PCR_PN_FB2_TYPE     6
`define PCR_PN_FORCE_RST    5
`define PCR_PN_HS_ALWAYS    4
`define PCR_PN_FAST_PLUS    3
`define PCR_PN_EN_KEEP      2
`define PCR_PN_IRQ_DEFER    1
`define PCR_PN_PAD_SUPPLY   0

// ==========================================================
// Field positions of the autostart and bypass registers
// ==========================================================
`define PCR_SW_PERI         7
`define PCR_SW_CORE         6
`define PCR_SW_CONV_HI      5
`define PCR_BYP_HI          7
`define PCR_BYP_LO          3
`define PCR_LIN_HI_AUTO     2

`endif

/* File: design/pcr_pkg.sv */
// Types shared by the power configuration bank.
package pcr_pkg;

	// ==========================================================
	// Source followed by the first linear regulator
	// ==========================================================
	typedef enum logic [1:0] {
		PCR_TRACK_NONE  = 2'h0,
		PCR_TRACK_PRO   = 2'h1,
		PCR_TRACK_CORE1 = 2'h2,
		PCR_TRACK_CORE2 = 2'h3
	} pcr_track_type;

endpackage

/* File: design/pcr_regs.sv */
// Power configuration register bank with its control outputs.
`timescale 1ns/1ps
`include "pcr_defs.svh"

module pcr_regs (
	// Clock and reset.
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	// Register port from the control interface.
	input  wire logic                      reg_wr_i,
	input  wire logic                      reg_rd_i,
	input  wire logic [`PCR_ADDR_W-1:0]    reg_addr_i,
	input  wire logic [`PCR_DATA_W-1:0]    reg_wdata_i,
	output logic      [`PCR_DATA_W-1:0]    reg_rdata_o,
	// Converter clock phase and rail control.
	output logic                           peripheral_converter_phase_flip_o,
	output logic                           io_converter_phase_flip_o,
	output logic                           memory_converter_phase_flip_o,
	output logic                           processor_converter_phase_flip_o,
	output logic                           core_one_converter_phase_flip_o,
	output logic                           core_two_converter_phase_flip_o,
	output logic                           rail_discharge_enable_o,
	output pcr_pkg::pcr_track_type         first_linear_track_select_o,
	// Feedback outputs, internal signals active low.
	input  wire logic                      fb3_int_n_i,
	input  wire logic                      fb2_int_n_i,
	input  wire logic                      fb2_is_power_good_i,
	output logic                           third_feedback_output_o,
	output logic                           second_feedback_output_o,
	output logic                           second_feedback_output_oe_o,
	// System reset pin.
	input  wire logic                      reset_req_n_i,
	output logic                           system_reset_pin_n_o,
	// Secondary 2-wire link and pad supply.
	output logic                           secondary_link_high_speed_always_o,
	output logic                           secondary_link_fast_plus_o,
	output logic                           input_pad_supply_select_o,
	// Global power enable reload.
	input  wire logic                      otp_second_read_i,
	input  wire logic                      otp_power_enable_i,
	output logic                           power_enable_o,
	// Interrupt request pin.
	input  wire logic                      irq_event_i,
	input  wire logic                      in_active_state_i,
	output logic                           interrupt_request_pin_n_o,
	// Power-up enables.
	input  wire logic                      powering_up_i,
	input  wire logic [1:0]                switch_conf_i,
	input  wire logic [5:0]                converter_conf_i,
	input  wire logic [10:0]               linear_conf_i,
	output logic      [1:0]                switch_enable_o,
	output logic      [5:0]                converter_enable_o,
	output logic      [10:0]               linear_enable_o,
	output logic      [4:0]                linear_bypass_o
);

	// ==========================================================
	// Register storage
	// ==========================================================
	logic [7:0]  phase_q;
	logic [7:0]  pin_q;
	logic [7:0]  sw_auto_q;
	logic [7:0]  lin_byp_q;
	logic [7:0]  lin_low_q;
	logic [7:0]  rdata_q;
	logic        fb3_q;
	logic        fb2_q;
	logic        fb2_oe_q;
	logic        rst_pin_n_q;
	logic        pwr_en_q;
	logic        irq_n_q;
	logic [1:0]  sw_en_q;
	logic [5:0]  conv_en_q;
	logic [10:0] lin_en_q;
	logic [1:0]  sw_auto;
	logic [5:0]  conv_auto;
	logic [10:0] lin_auto;

	// Write decode; each register takes the byte on a write to its offset.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_q   <= `PCR_RST_PHASE;
			pin_q     <= `PCR_RST_PIN;
			sw_auto_q <= `PCR_RST_SW_AUTO;
			lin_byp_q <= `PCR_RST_LIN_BYP;
			lin_low_q <= `PCR_RST_LIN_LOW;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				`PCR_OFS_PHASE:   phase_q   <= reg_wdata_i;
				`PCR_OFS_PIN:     pin_q     <= reg_wdata_i;
				`PCR_OFS_SW_AUTO: sw_auto_q <= reg_wdata_i;
				`PCR_OFS_LIN_BYP: lin_byp_q <= reg_wdata_i;
				`PCR_OFS_LIN_LOW: lin_low_q <= reg_wdata_i;
				default: ;
			endcase
		end
	end

	// Read data is captured on the edge that samples the read and shows the cycle after; unmapped offsets return zero.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= `PCR_RDATA_NONE;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				`PCR_OFS_PHASE:   rdata_q <= phase_q;
				`PCR_OFS_PIN:     rdata_q <= pin_q;
				`PCR_OFS_SW_AUTO: rdata_q <= sw_auto_q;
				`PCR_OFS_LIN_BYP: rdata_q <= lin_byp_q;
				`PCR_OFS_LIN_LOW: rdata_q <= lin_low_q;
				default:          rdata_q <= `PCR_RDATA_NONE;
			endcase
		end
	end
	assign reg_rdata_o = rdata_q;

	// ==========================================================
	// Static configuration levels
	// ==========================================================
	// Phase, discharge and tracking fields go straight from the flip-flops; the core-two phase is the inverted core-one bit.
	assign peripheral_converter_phase_flip_o = phase_q[`PCR_PH_PERI];
	assign io_converter_phase_flip_o         = phase_q[`PCR_PH_IO];
	assign memory_converter_phase_flip_o     = phase_q[`PCR_PH_MEM];
	assign processor_converter_phase_flip_o  = phase_q[`PCR_PH_PRO];
	assign core_one_converter_phase_flip_o   = phase_q[`PCR_PH_CORE1];
	assign core_two_converter_phase_flip_o   = ~phase_q[`PCR_PH_CORE1];
	assign rail_discharge_enable_o           = phase_q[`PCR_PH_DISCHG];
	assign first_linear_track_select_o       =
		pcr_pkg::pcr_track_type'(phase_q[`PCR_PH_TRACK_HI:`PCR_PH_TRACK_LO]);

	// Interface options, pad supply and bypass levels.
	assign secondary_link_high_speed_always_o = pin_q[`PCR_PN_HS_ALWAYS];
	assign secondary_link_fast_plus_o         = pin_q[`PCR_PN_FAST_PLUS];
	assign input_pad_supply_select_o          = pin_q[`PCR_PN_PAD_SUPPLY];
	assign linear_bypass_o = lin_byp_q[`PCR_BYP_HI:`PCR_BYP_LO];

	// ==========================================================
	// Pin drivers
	// ==========================================================
	// Third feedback: polarity 1 inverts the active-low internal signal.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fb3_q <= 1'b1;
		end else begin
			fb3_q <= pin_q[`PCR_PN_FB3_POL] ? ~fb3_int_n_i : fb3_int_n_i;
		end
	end
	assign third_feedback_output_o = fb3_q;

	// Second feedback: for power-good, type 1 is open drain that releases when asserted.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fb2_q    <= 1'b1;
			fb2_oe_q <= 1'b1;
		end else if (fb2_is_power_good_i && pin_q[`PCR_PN_FB2_TYPE]) begin
			fb2_q    <= 1'b0;
			fb2_oe_q <= fb2_int_n_i;
		end else begin
			fb2_q    <= pin_q[`PCR_PN_FB2_TYPE] ? ~fb2_int_n_i : fb2_int_n_i;
			fb2_oe_q <= 1'b1;
		end
	end
	assign second_feedback_output_o    = fb2_q;
	assign second_feedback_output_oe_o = fb2_oe_q;

	// System reset pin is held low while forced, otherwise follows other sources.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_pin_n_q <= 1'b0;
		end else begin
			rst_pin_n_q <= reset_req_n_i & ~pin_q[`PCR_PN_FORCE_RST];
		end
	end
	assign system_reset_pin_n_o = rst_pin_n_q;

	// Interrupt pin asserts at once, or only once active when deferral is chosen.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_n_q <= 1'b1;
		end else begin
			irq_n_q <= ~(irq_event_i &
				(~pin_q[`PCR_PN_IRQ_DEFER] | in_active_state_i));
		end
	end
	assign interrupt_request_pin_n_o = irq_n_q;

	// ==========================================================
	// Power enable and power-up enables
	// ==========================================================
	// Global power enable is reloaded on the second memory read unless kept.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwr_en_q <= 1'b0;
		end else if (otp_second_read_i && !pin_q[`PCR_PN_EN_KEEP]) begin
			pwr_en_q <= otp_power_enable_i;
		end
	end
	assign power_enable_o = pwr_en_q;

	// Autostart vectors gathered in output bit order.
	assign sw_auto   = sw_auto_q[`PCR_SW_PERI:`PCR_SW_CORE];
	assign conv_auto = sw_auto_q[`PCR_SW_CONV_HI:0];
	assign lin_auto  = {lin_byp_q[`PCR_LIN_HI_AUTO:0], lin_low_q};

	// While powering up a set autostart bit forces the rail on over its own control.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sw_en_q   <= 2'h0;
			conv_en_q <= 6'h00;
			lin_en_q  <= 11'h000;
		end else if (powering_up_i) begin
			sw_en_q   <= switch_conf_i | sw_auto;
			conv_en_q <= converter_conf_i | conv_auto;
			lin_en_q  <= linear_conf_i | lin_auto;
		end else begin
			sw_en_q   <= switch_conf_i;
			conv_en_q <= converter_conf_i;
			lin_en_q  <= linear_conf_i;
		end
	end
	assign switch_enable_o    = sw_en_q;
	assign converter_enable_o = conv_en_q;
	assign linear_enable_o    = lin_en_q;

	// ==========================================================
	// Checks
	// ==========================================================
	AST_CORE_TWO_OPPOSITE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		core_two_converter_phase_flip_o != core_one_converter_phase_flip_o)
		else $error("Core-two phase not opposite to core-one.");

	AST_READBACK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(reg_wr_i && reg_addr_i == `PCR_OFS_PIN) ##1
		(reg_rd_i && !reg_wr_i && reg_addr_i == `PCR_OFS_PIN)
		|=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("Read back differs from written value.");

	AST_FORCE_RESET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pin_q[`PCR_PN_FORCE_RST] |=> !system_reset_pin_n_o)
		else $error("Reset pin released while forced.");

	AST_OTP_RELOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(otp_second_read_i && !pin_q[`PCR_PN_EN_KEEP])
		|=> power_enable_o == $past(otp_power_enable_i))
		else $error("Power enable not reloaded.");

	AST_OTP_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(otp_second_read_i && pin_q[`PCR_PN_EN_KEEP]) |=> $stable(power_enable_o))
		else $error("Power enable changed while kept.");

	AST_IRQ_DEFER: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pin_q[`PCR_PN_IRQ_DEFER] && !in_active_state_i) |=> interrupt_request_pin_n_o)
		else $error("Interrupt asserted before active.");

	AST_IRQ_NOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(irq_event_i && !pin_q[`PCR_PN_IRQ_DEFER]) |=> !interrupt_request_pin_n_o)
		else $error("Immediate interrupt not asserted.");

	AST_FB3_POL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pin_q[`PCR_PN_FB3_POL] |=> third_feedback_output_o == !$past(fb3_int_n_i))
		else $error("Third feedback not inverted.");

	AST_FB2_OD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pin_q[`PCR_PN_FB2_TYPE] && fb2_is_power_good_i)
		|=> !second_feedback_output_o && second_feedback_output_oe_o == $past(fb2_int_n_i))
		else $error("Second feedback not open drain.");

	AST_LINEAR_AUTO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(powering_up_i && lin_low_q[0]) |=> linear_enable_o[0])
		else $error("Autostart did not force linear one on.");

	AST_SWITCH_AUTO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(powering_up_i && sw_auto_q[`PCR_SW_PERI]) |=> switch_enable_o[1])
		else $error("Autostart did not force peripheral switch on.");

	AST_CONF_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!powering_up_i |=> converter_enable_o == $past(converter_conf_i))
		else $error("Converter enable ignored its own control.");

	AST_CONV_AUTO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(powering_up_i && sw_auto_q[0]) |=> converter_enable_o[0])
		else $error("Autostart did not force core-one converter on.");

	AST_RDATA_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("Read data changed without a read.");

endmodule

/* File: sim/pcr_pin_model.sv */
// Board-side model of the second feedback pin with its external pull-up.
`timescale 1ns/1ps

module pcr_pin_model (
	// Pin drive from the configuration bank.
	input  wire logic fb2_o_i,
	input  wire logic fb2_oe_i,
	// Level seen on the board.
	output logic      fb2_pin_o
);
	// The pull-up sets the line high whenever the bank releases it.
	assign fb2_pin_o = fb2_oe_i ? fb2_o_i : 1'b1;
endmodule

/* File: sim/pcr_tb.sv */
// Self-checking bench of the power configuration register bank.
`timescale 1ns/1ps
`include "pcr_defs.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench;
	typedef struct packed {logic [8:0] a; logic [7:0] d; logic [7:0] s;
		logic [7:0] r;} pcr_row_type;
	logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, pat, fb2_pin;
	logic [8:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o;
	logic fb3_int_n_i, fb2_int_n_i, fb2_is_power_good_i, reset_req_n_i, otp_second_read_i;
	logic otp_power_enable_i, irq_event_i, in_active_state_i, powering_up_i;
	logic peripheral_converter_phase_flip_o, io_converter_phase_flip_o;
	logic memory_converter_phase_flip_o, processor_converter_phase_flip_o;
	logic core_one_converter_phase_flip_o, core_two_converter_phase_flip_o;
	logic rail_discharge_enable_o, third_feedback_output_o, second_feedback_output_o;
	logic second_feedback_output_oe_o, system_reset_pin_n_o, power_enable_o;
	logic secondary_link_high_speed_always_o, secondary_link_fast_plus_o;
	logic input_pad_supply_select_o, interrupt_request_pin_n_o;
	pcr_pkg::pcr_track_type first_linear_track_select_o;
	logic [1:0] switch_conf_i, switch_enable_o;
	logic [5:0] converter_conf_i, converter_enable_o;
	logic [10:0] linear_conf_i, linear_enable_o;
	logic [4:0] linear_bypass_o;
	logic [7:0] sh [5];
	int err_count, samples_checked;
	// Side byte: fb3_n, fb2_n, power-good, reset request, irq, active, powering up, pattern.
	// Last byte is the read-back expected; unmapped offsets read zero.
	// Phase rows keep processor and memory polarity opposite.
	pcr_row_type rows [17] = '{
		'{9'h108, 8'hA5, 8'hF2, 8'hA5}, '{9'h108, 8'h5A, 8'h0D, 8'h5A},
		'{9'h108, 8'h2B, 8'h3A, 8'h2B}, '{9'h108, 8'hD4, 8'hC5, 8'hD4},
		'{9'h109, 8'hAA, 8'h5E, 8'hAA}, '{9'h109, 8'hFF, 8'hF8, 8'hFF},
		'{9'h109, 8'h55, 8'h6B, 8'h55}, '{9'h109, 8'h55, 8'h2A, 8'h55},
		'{9'h109, 8'h00, 8'h18, 8'h00}, '{9'h10A, 8'hC3, 8'h02, 8'hC3},
		'{9'h10A, 8'h3C, 8'h03, 8'h3C}, '{9'h10B, 8'hA5, 8'h02, 8'hA5},
		'{9'h10B, 8'h5A, 8'h01, 8'h5A}, '{9'h10C, 8'h81, 8'h03, 8'h81},
		'{9'h10C, 8'h7E, 8'h02, 8'h7E}, '{9'h107, 8'hFF, 8'h00, 8'h00},
		'{9'h10D, 8'hFF, 8'h01, 8'h00}};

	// Configuration inputs alternate between two patterns.
	assign switch_conf_i    = pat ? 2'h1 : 2'h2;
	assign converter_conf_i = pat ? 6'h15 : 6'h2A;
	assign linear_conf_i    = pat ? 11'h555 : 11'h2AA;

	pcr_regs i_dut (.clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .peripheral_converter_phase_flip_o, .io_converter_phase_flip_o,
		.memory_converter_phase_flip_o, .processor_converter_phase_flip_o,
		.core_one_converter_phase_flip_o, .core_two_converter_phase_flip_o,
		.rail_discharge_enable_o, .first_linear_track_select_o, .fb3_int_n_i, .fb2_int_n_i,
		.fb2_is_power_good_i, .third_feedback_output_o, .second_feedback_output_o,
		.second_feedback_output_oe_o, .reset_req_n_i, .system_reset_pin_n_o,
		.secondary_link_high_speed_always_o, .secondary_link_fast_plus_o,
		.input_pad_supply_select_o, .otp_second_read_i, .otp_power_enable_i, .power_enable_o,
		.irq_event_i, .in_active_state_i, .interrupt_request_pin_n_o, .powering_up_i,
		.switch_conf_i, .converter_conf_i, .linear_conf_i, .switch_enable_o,
		.converter_enable_o, .linear_enable_o, .linear_bypass_o);

	pcr_pin_model i_pin (.fb2_o_i(second_feedback_output_o),
		.fb2_oe_i(second_feedback_output_oe_o), .fb2_pin_o(fb2_pin));

	// Free-running 200 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Compares every control output except power_enable_o with values worked out from the shadow copy.
	task automatic chk_out();
		logic t2, eo, eoe;
		t2  = sh[1][6];
		eo  = (t2 & fb2_is_power_good_i) ? 1'b0 : (t2 ? ~fb2_int_n_i : fb2_int_n_i);
		eoe = (t2 & fb2_is_power_good_i) ? fb2_int_n_i : 1'b1;
		`CHK({peripheral_converter_phase_flip_o, io_converter_phase_flip_o,
			memory_converter_phase_flip_o, processor_converter_phase_flip_o,
			core_one_converter_phase_flip_o}, sh[0][7:3])
		`CHK(core_two_converter_phase_flip_o, ~sh[0][3])
		`CHK(rail_discharge_enable_o, sh[0][2])
		`CHK(first_linear_track_select_o, sh[0][1:0])
		`CHK(third_feedback_output_o, sh[1][7] ? ~fb3_int_n_i : fb3_int_n_i)
		`CHK({second_feedback_output_o, second_feedback_output_oe_o}, {eo, eoe})
		`CHK(fb2_pin, eoe ? eo : 1'b1)
		`CHK(system_reset_pin_n_o, reset_req_n_i & ~sh[1][5])
		`CHK(secondary_link_high_speed_always_o, sh[1][4])
		`CHK(secondary_link_fast_plus_o, sh[1][3])
		`CHK(interrupt_request_pin_n_o,
			~(irq_event_i & (~sh[1][1] | in_active_state_i)))
		`CHK(input_pad_supply_select_o, sh[1][0])
		`CHK(switch_enable_o, switch_conf_i | (powering_up_i ? sh[2][7:6] : 2'h0))
		`CHK(converter_enable_o,
			converter_conf_i | (powering_up_i ? sh[2][5:0] : 6'h00))
		`CHK(linear_bypass_o, sh[3][7:3])
		`CHK(linear_enable_o,
			linear_conf_i | (powering_up_i ? {sh[3][2:0], sh[4]} : 11'h000))
	endtask

	// One optional write then one read of the same address, then all outputs but power_enable_o.
	task automatic acc(input logic [8:0] a, input logic [7:0] d, input logic w,
		input logic [7:0] e);
		logic mapped;
		mapped = (a >= 9'h108) && (a <= 9'h10C);
		reg_addr_i  = a;
		reg_wdata_i = d;
		reg_wr_i    = w;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b1;
		if (w && mapped) sh[a - 9'h108] = d;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		`CHK(reg_rdata_o, e)
		chk_out();
	endtask

	// One pulse of the second memory read.
	task automatic otp_read(input logic v);
		otp_power_enable_i = v;
		otp_second_read_i  = 1'b1;
		@(negedge clk_i);
		otp_second_read_i = 1'b0;
		@(negedge clk_i);
	endtask

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Cuts a hang short at 400 cycles, well beyond the expected run of about 75.
	initial begin
		#2000;
		err_count++;
		$display("timeout reached");
		end_sim();
	end

	// Main sequence: table rows, then hand-written cases.
	initial begin
		{rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, pat} = '0;
		{fb3_int_n_i, fb2_int_n_i, fb2_is_power_good_i, reset_req_n_i} = 4'hF;
		{otp_second_read_i, otp_power_enable_i, irq_event_i, in_active_state_i} = 4'h0;
		powering_up_i = 1'b0;
		for (int k = 0; k < 5; k++) sh[k] = 8'h00;
		repeat (12) @(posedge clk_i);
		@(negedge clk_i);
		`CHK(core_two_converter_phase_flip_o, 1'b1)
		rst_n_i = 1'b1;
		for (int i = 0; i < 17; i++) begin
			{fb3_int_n_i, fb2_int_n_i, fb2_is_power_good_i, reset_req_n_i, irq_event_i,
				in_active_state_i, powering_up_i, pat} = rows[i].s;
			acc(rows[i].a, rows[i].d, 1'b1, rows[i].r);
		end
		$display("table rows done");
		acc(9'h109, 8'h00, 1'b1, 8'h00);
		otp_read(1'b1);
		`CHK(power_enable_o, 1'b1)
		acc(9'h109, 8'h04, 1'b1, 8'h04);
		otp_read(1'b0);
		`CHK(power_enable_o, 1'b1)
		acc(9'h109, 8'h00, 1'b1, 8'h00);
		otp_read(1'b0);
		`CHK(power_enable_o, 1'b0)
		$display("power enable reload done");
		reg_addr_i  = 9'h10C;
		reg_wdata_i = 8'h3C;
		{reg_wr_i, reg_rd_i} = 2'b11;
		@(negedge clk_i);
		{reg_wr_i, reg_rd_i} = 2'b00;
		@(negedge clk_i);
		`CHK(reg_rdata_o, 8'h7E)
		sh[4] = 8'h3C;
		acc(9'h10C, 8'h00, 1'b0, 8'h3C);
		$display("same edge access done");
		rst_n_i = 1'b0;
		@(negedge clk_i);
		`CHK(core_two_converter_phase_flip_o, 1'b1)
		`CHK(reg_rdata_o, 8'h00)
		rst_n_i = 1'b1;
		for (int k = 0; k < 5; k++) sh[k] = 8'h00;
		for (int k = 0; k < 5; k++) acc(9'h108 + 9'(k), 8'h00, 1'b0, 8'h00);
		$display("mid-run reset done");
		end_sim();
	end
endmodule
